/* File: hw/dual_octal_register_mux.sv */
// Overview of operation
// RULE1: sixteen flops as two 8-bit registers, shared clock
// RULE2: both registers load on every clock rise; the code loads nothing on a rise that comes while CE is low
// RULE3: eight two-input muxes pick one register word
// RULE4: select low gives B, high gives A
// RULE5: outputs drive only while clock pulse high
// RULE6: source loads 16 bits, then toggles select
// RULE7: outputs show stored contents, never live inputs
// RULE8: storage registers have no reset value
`timescale 1ns/1ps
`default_nettype none

`include "dual_octal_regs.svh"

module dual_octal_register_mux #(
  parameter int DEPTH = `DOR_BUF_DEPTH
) (
  // clock, reset, enable
  input  wire logic                  CLK,
  input  wire logic                  ARST_N,
  input  wire logic                  CE,
  // pins from the bus logic
  input  wire dual_octal_pkg::octet_t DATA_A,
  input  wire dual_octal_pkg::octet_t DATA_B,
  input  wire logic                  SELECT_A,
  input  wire logic                  CLOCK_PULSE,
  // three-state output word
  output var  dual_octal_pkg::octet_t OUT_WORD,
  output var  dual_octal_pkg::octet_t OUT_OE,
  // buffered word stream
  output var  dual_octal_pkg::octet_t WORD_DATA,
  output var  logic                  WORD_VALID,
  input  wire logic                  WORD_READY,
  output var  logic                  BUF_READY
);
  import dual_octal_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (DEPTH < 2) begin : g_bad_depth
    $error("buffer depth must be at least two");
  end

  // ****************************************************************
  // pin synchroniser, three stages
  // ****************************************************************
  pins_t sync1_ff;
  pins_t sync2_ff;
  pins_t sync3_ff;
  logic  cp_lvl_ff;
  logic  sel_lvl_ff;
  logic  nxt_cp_lvl;
  logic  nxt_sel_lvl;

  // first stage feeds only the second
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
      sync3_ff <= '0;
    end else if (CE) begin
      sync1_ff <= {CLOCK_PULSE, SELECT_A, DATA_B, DATA_A};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  // a level change counts once stages two and three agree
  function automatic logic agreed(input logic s2, input logic s3,
                                  input logic held);
    return (s2 == s3) ? s3 : held;
  endfunction : agreed

  // same filter for both control pins, so they settle alike
  assign nxt_cp_lvl  = agreed(sync2_ff[`DOR_BIT_CP], sync3_ff[`DOR_BIT_CP],
                              cp_lvl_ff);
  assign nxt_sel_lvl = agreed(sync2_ff[`DOR_BIT_SEL], sync3_ff[`DOR_BIT_SEL],
                              sel_lvl_ff);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cp_lvl_ff  <= 1'b0;
      sel_lvl_ff <= 1'b0;
    end else if (CE) begin
      cp_lvl_ff  <= nxt_cp_lvl;
      sel_lvl_ff <= nxt_sel_lvl;
    end
  end

  // ****************************************************************
  // storage registers
  // ****************************************************************
  octet_t reg_a_ff;
  octet_t reg_b_ff;
  wire    load_rise = CE && nxt_cp_lvl && !cp_lvl_ff;

  // no reset: contents undefined until the first rise
  always_ff @(posedge CLK) begin // RULE8
    if (load_rise) begin // RULE2
      reg_a_ff <= sync3_ff[`DOR_WORD_W-1:0]; // RULE1
      reg_b_ff <= sync3_ff[2*`DOR_WORD_W-1:`DOR_WORD_W]; // RULE1
    end
  end

  // ****************************************************************
  // output multiplexer and drivers
  // ****************************************************************
  octet_t out_word_ff;
  octet_t out_oe_ff;
  wire octet_t mux_word = sel_lvl_ff ? reg_a_ff : reg_b_ff; // RULE3 RULE4

  // stored word only, driven while the clock pulse is high
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_word_ff <= `DOR_OUT_RST;
      out_oe_ff   <= '0;
    end else if (CE) begin
      out_word_ff <= cp_lvl_ff ? mux_word : `DOR_OUT_RST; // RULE7
      out_oe_ff   <= {`DOR_WORD_W{cp_lvl_ff}}; // RULE5
    end
  end

  assign OUT_WORD = out_word_ff;
  assign OUT_OE   = out_oe_ff;

  // ****************************************************************
  // word stream: one push per newly presented word
  // ****************************************************************
  logic   last_sel_ff;
  logic   push_req;
  logic   push;
  logic   pop;
  octet_t mem_ff [DEPTH];
  logic   [DEPTH-1:0] vld_ff;
  logic   [CW-1:0]    count_ff;
  logic   ready_ff;
  octet_t nxt_mem [DEPTH];
  logic   [DEPTH-1:0] nxt_vld;
  logic   [CW-1:0]    nxt_count;
  logic   [CW-1:0]    cnt_left;

  // a word is pushed when the pulse rises and again on each select change
  assign push_req = cp_lvl_ff
                    && (!out_oe_ff[0] || sel_lvl_ff != last_sel_ff); // RULE6
  assign push     = push_req && (count_ff != CW'(DEPTH));
  assign pop      = vld_ff[0] && WORD_READY;
  assign cnt_left = count_ff - CW'(pop);
  assign nxt_count = cnt_left + CW'(push);

  // head sits in entry zero, entries shift on pop
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      nxt_mem[i] = (pop && i < DEPTH - 1) ? mem_ff[(i + 1) % DEPTH]
                                          : mem_ff[i];
      nxt_vld[i] = CW'(i) < cnt_left;
      if (push && CW'(i) == cnt_left) begin
        nxt_mem[i] = mux_word;
        nxt_vld[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= '0;
      vld_ff      <= '0;
      count_ff    <= '0;
      ready_ff    <= 1'b0;
      last_sel_ff <= 1'b0;
    end else if (CE) begin
      mem_ff      <= nxt_mem;
      vld_ff      <= nxt_vld;
      count_ff    <= nxt_count;
      ready_ff    <= nxt_count != CW'(DEPTH);
      last_sel_ff <= push ? sel_lvl_ff : last_sel_ff;
    end
  end

  assign WORD_DATA  = mem_ff[0];
  assign WORD_VALID = vld_ff[0];
  assign BUF_READY  = ready_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_load_both: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE2
    load_rise |=> reg_a_ff == $past(sync3_ff[7:0])
                  && reg_b_ff == $past(sync3_ff[15:8]))
    else $error("registers missed a load on clock rise");
  a_hold_regs: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE1
    (!load_rise && cp_lvl_ff) ##1 cp_lvl_ff |-> $stable(reg_a_ff)
                                  && $stable(reg_b_ff))
    else $error("registers changed without a clock rise");
  a_drive_high: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE5
    CE && cp_lvl_ff |=> OUT_OE == 8'hff)
    else $error("outputs not driven while clock pulse high");
  a_float_low: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE5
    CE && !cp_lvl_ff |=> OUT_OE == 8'h00)
    else $error("outputs driven while clock pulse low");
  a_pick_b: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE4
    CE && cp_lvl_ff && !sel_lvl_ff |=> OUT_WORD == $past(reg_b_ff))
    else $error("select low did not give register B");
  a_pick_a: assert property (@(posedge CLK) disable iff (!ARST_N) // RULE4
    CE && cp_lvl_ff && sel_lvl_ff |=> OUT_WORD == $past(reg_a_ff))
    else $error("select high did not give register A");
  a_sync_agree: assert property (@(posedge CLK) disable iff (!ARST_N)
    $changed(cp_lvl_ff) |-> $past(sync2_ff[17]) == $past(sync3_ff[17]))
    else $error("clock pulse level changed without agreement");
  a_buf_full: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && push && count_ff == CW'(DEPTH - 1) && !pop |=> !BUF_READY)
    else $error("buffer ready stayed high when full");
  a_pop_shift: assert property (@(posedge CLK) disable iff (!ARST_N)
    CE && pop && vld_ff[1] |=> WORD_VALID && WORD_DATA == $past(mem_ff[1]))
    else $error("second entry did not move to head");
  a_freeze_ce: assert property (@(posedge CLK) disable iff (!ARST_N)
    !CE |=> $stable(cp_lvl_ff) && $stable(count_ff) && $stable(OUT_OE))
    else $error("state moved while clock enable was low");

  c_rise: cover property (@(posedge CLK) disable iff (!ARST_N) load_rise);
  c_split: cover property (@(posedge CLK) disable iff (!ARST_N)
    push && !sel_lvl_ff ##[1:20] push && sel_lvl_ff);
  c_full: cover property (@(posedge CLK) disable iff (!ARST_N)
    !BUF_READY ##1 BUF_READY);
  c_freeze: cover property (@(posedge CLK) disable iff (!ARST_N)
    !CE ##1 CE);

endmodule : dual_octal_register_mux

`default_nettype wire

/* File: shared/dual_octal_regs.svh */
`ifndef DUAL_OCTAL_REGS_SVH
`define DUAL_OCTAL_REGS_SVH

// ****************************************************************
// widths, bit positions, depth and reset values
// ****************************************************************
`define DOR_WORD_W     8
`define DOR_SYNC_W     18
`define DOR_BIT_CP     17
`define DOR_BIT_SEL    16
`define DOR_BUF_DEPTH  2
`define DOR_OUT_RST    8'h00

`endif

/* File: shared/dual_octal_pkg.sv */
`default_nettype none

`include "dual_octal_regs.svh"

package dual_octal_pkg;
  // one 8-bit register word
  typedef logic [`DOR_WORD_W-1:0] octet_t;
  // all synchronised pins: clock pulse, select, B word, A word
  typedef logic [`DOR_SYNC_W-1:0] pins_t;
endpackage : dual_octal_pkg

`default_nettype wire

/* File: testbench/word_sink.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// far-side sink with random and forced stalls
// ****************************************
module word_sink (
  // clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // stall request from the bench
  input  wire logic stall,
  // ready toward the word stream
  output var  logic ready
);
  int seed = 32'h12b8;
  // ready changes only just after a rising edge
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready <= 1'b0;
    end else begin
      ready <= !stall && ($random(seed) % 2 != 0); // random stalls
    end
  end
endmodule : word_sink
`default_nettype wire

/* File: testbench/dual_octal_register_mux_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// bench top
// ****************************************
module dual_octal_register_mux_tb_top;
  import dual_octal_pkg::*;
  logic   clk = 1'b0, arst_n = 1'b0, sel = 1'b0, cp = 1'b0, stall = 1'b0;
  octet_t da = 8'h00, db = 8'h00, q, oe, wd, a, b;
  logic   wv, wr, br;
  logic   ce = 1'b1;
  int     err_total = 0, total_checks = 0, seed = 32'h12b8;
  octet_t expq[$];
  always #2.5 clk = ~clk;
  dual_octal_register_mux dut (.CLK(clk), .ARST_N(arst_n), .CE(ce),
    .DATA_A(da), .DATA_B(db), .SELECT_A(sel), .CLOCK_PULSE(cp),
    .OUT_WORD(q), .OUT_OE(oe), .WORD_DATA(wd), .WORD_VALID(wv),
    .WORD_READY(wr), .BUF_READY(br));
  word_sink sink (.clk(clk), .arst_n(arst_n), .stall(stall), .ready(wr));
  // compare one value, report and count
  task automatic check(input octet_t seen, input octet_t exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // expected output word for a select level: high gives A, low gives B
  function automatic octet_t pick(input octet_t va, input octet_t vb,
                                  input logic sel_a);
    return sel_a ? va : vb;
  endfunction : pick
  task automatic stop_test;
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // one frame: load both words, send B then A, optional third toggle
  task automatic frame(input octet_t va, input octet_t vb, input bit extra);
    da <= va;
    db <= vb;
    sel <= 1'b0;
    cyc(5);
    cp <= 1'b1;
    expq.push_back(vb);
    cyc(8);
    check(oe, 8'hff);
    check(q, pick(va, vb, 1'b0));
    sel <= 1'b1;
    expq.push_back(va);
    cyc(8);
    check(q, pick(va, vb, 1'b1));
    da <= ~va;
    db <= ~vb;
    cyc(8);
    check(q, pick(va, vb, 1'b1));
    if (extra) begin
      sel <= 1'b0;
      cyc(8);
      check(q, pick(va, vb, 1'b0));
      check({7'h00, br}, 8'h00);
    end
    cp <= 1'b0;
    cyc(8);
    check(oe, 8'h00);
    check(q, 8'h00);
    cyc(12);
  endtask : frame
  // stream monitor: words leave in push order
  always @(posedge clk) begin
    if (wv === 1'b1 && wr === 1'b1) begin
      if (expq.size() == 0) check(8'(expq.size()), 8'h01);
      else check(wd, expq.pop_front());
    end
  end
  // watchdog: about twenty times the length of the full run
  initial begin
    #50000;
    err_total++;
    stop_test();
  end
  initial begin
    cyc(12);
    arst_n <= 1'b1;
    cyc(2);
    frame(8'hff, 8'h00, 1'b0);
    for (int i = 0; i < 6; i++) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      frame(a, b, 1'b0);
    end
    stall <= 1'b1;
    frame(8'h5a, 8'ha5, 1'b1);
    stall <= 1'b0;
    cyc(40);
    check(8'(expq.size()), 8'h00);
    // frozen clock enable: a whole pulse passes unseen
    ce <= 1'b0;
    cp <= 1'b1;
    cyc(8);
    check(oe, 8'h00);
    cp <= 1'b0;
    cyc(8);
    ce <= 1'b1;
    cyc(8);
    check(oe, 8'h00);
    check(q, 8'h00);
    check({7'h00, wv}, 8'h00);
    stop_test();
  end
endmodule : dual_octal_register_mux_tb_top
`default_nettype wire
